// file: hdl/lddc_pkg.sv
// Constants shared by the double-data-rate sample capture block and its FIFO.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lddc_pkg;
  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int LDDC_LANES      = 16;
  localparam int LDDC_FIFO_DEPTH = 8;
  localparam int LDDC_ENTRY_W    = 2 * LDDC_LANES + 2;
  // ****************************************************************
  // Field positions inside one FIFO entry
  // ****************************************************************
  localparam int LDDC_POS_PARITY = 0;
  localparam int LDDC_POS_SOF    = 1;
  localparam int LDDC_POS_FALL   = 2;
  localparam int LDDC_POS_RISE   = 2 + LDDC_LANES;
  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [1:0]  LDDC_RST_SYNC = 2'h0;
  localparam logic [15:0] LDDC_WORD_RST = 16'h0000;
  localparam logic        LDDC_BIT_RST  = 1'h0;
endpackage : lddc_pkg
`default_nettype wire

// file: hdl/lddc_async_fifo.sv
// Dual-clock FIFO with gray-coded pointers, storage in flip-flops.
// Assumes DEPTH is a power of two of at least 4 and that each side has
// its own reset, released in its own clock domain.
`default_nettype none
module lddc_async_fifo
  import lddc_pkg::*;
#(
  parameter int WIDTH = LDDC_ENTRY_W,
  parameter int DEPTH = LDDC_FIFO_DEPTH
) (
  input  wire logic             wr_clk,
  input  wire logic             wr_rst_n,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_clk,
  input  wire logic             rd_rst_n,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wbin;
    logic [AW:0]                 wgray;
    logic [AW:0]                 rq1;
    logic [AW:0]                 rq2;
  } lddc_fw_s;

  typedef struct packed {
    logic [AW:0] rbin;
    logic [AW:0] rgray;
    logic [AW:0] wq1;
    logic [AW:0] wq2;
  } lddc_fr_s;

  lddc_fw_s w;
  lddc_fw_s next_w;
  lddc_fr_s r;
  lddc_fr_s next_r;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // ****************************************************************
  // Write side
  // ****************************************************************
  // Full when the write pointer leads the synchronised read pointer by
  // exactly one lap; the view of the read side is stale, so full is
  // pessimistic and never lies.
  assign wr_ready = (w.wgray != {~w.rq2[AW:AW-1], w.rq2[AW-2:0]});

  always_comb begin
    next_w     = w;
    next_w.rq1 = r.rgray;
    next_w.rq2 = w.rq1;
    if (wr_valid && wr_ready) begin
      next_w.mem[w.wbin[AW-1:0]] = wr_data;
      next_w.wbin                = w.wbin + 1'b1;
      next_w.wgray               = to_gray(w.wbin + 1'b1);
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      w <= '0;
    end else begin
      w <= next_w;
    end
  end

  // ****************************************************************
  // Read side
  // ****************************************************************
  assign rd_valid = (r.rgray != r.wq2);
  // The addressed slot was written at least two read clocks before it
  // became visible, so it is stable when sampled here.
  assign rd_data  = w.mem[r.rbin[AW-1:0]];

  always_comb begin
    next_r     = r;
    next_r.wq1 = w.wgray;
    next_r.wq2 = r.wq1;
    if (rd_valid && rd_ready) begin
      next_r.rbin  = r.rbin + 1'b1;
      next_r.rgray = to_gray(r.rbin + 1'b1);
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule // lddc_async_fifo
`default_nettype wire

// file: hdl/lddc_capture.sv
// Capture of a 16-lane double-data-rate sample bus with a frame marker
// lane, handed to the system clock domain through a dual-clock FIFO.
// Assumes the source drives lanes and marker from the same launch clock
// as the data clock, and that the configuration inputs are static or
// change only between frames.
//
// Overview of operation
// (R1) Sample all lanes on both clock edges.
// (R2) Lane fifteen is MSB, lane zero LSB.
// (R3) Swap bit reverses captured word bit order.
// (R4) Rising marker resets pointer or syncs.
// (R5) Falling marker sample serves as parity bit.
// (R6) Source aligns marker edges with data edges.
// (R7) Marker start indicates beginning of a frame.
`default_nettype none
module lddc_capture
  import lddc_pkg::*;
#(
  parameter int LANES = LDDC_LANES,
  parameter int DEPTH = LDDC_FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             source_sync_data_clock,
  input  wire logic [LANES-1:0] data_lanes,
  input  wire logic             frame_marker_input,
  input  wire logic             bus_order_swap,
  input  wire logic             frame_use_sync,
  input  wire logic             overflow_clear,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [LANES-1:0] out_rise_word,
  output logic      [LANES-1:0] out_fall_word,
  output logic                  out_sof,
  output logic                  out_parity,
  output logic                  fifo_ptr_reset,
  output logic                  frame_sync_pulse,
  output logic                  overflow_seen
);
  localparam int EW = 2 * LANES + 2;

  // ****************************************************************
  // Reset release in both domains
  // ****************************************************************
  logic [1:0] mrst_q;
  logic [1:0] lrst_q;
  logic       mrst_n;
  logic       lrst_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mrst_q <= LDDC_RST_SYNC;
    end else begin
      mrst_q <= {mrst_q[0], 1'b1};
    end
  end

  always_ff @(posedge source_sync_data_clock or negedge rst_n) begin
    if (!rst_n) begin
      lrst_q <= LDDC_RST_SYNC;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  assign mrst_n = mrst_q[1];
  assign lrst_n = lrst_q[1];

  // ****************************************************************
  // Link domain state
  // ****************************************************************
  typedef struct packed {
    logic [LANES-1:0] word;
    logic             marker;
  } lddc_fall_s;

  typedef struct packed {
    logic [LANES-1:0] rise_word;
    logic             frame_rise;
    logic             frame_prev;
    logic             primed;
    logic             swap_q1;
    logic             swap_q2;
    logic             sof_tgl;
    logic             ovf_tgl;
  } lddc_link_s;

  lddc_fall_s fl;
  lddc_fall_s next_fl;
  lddc_link_s lk;
  lddc_link_s next_lk;

  logic [LANES-1:0] rev_rise;
  logic [LANES-1:0] rev_fall;
  logic [LANES-1:0] ord_rise;
  logic [LANES-1:0] ord_fall;
  logic             link_sof;
  logic             wr_ready;
  logic [EW-1:0]    wr_data;

  // ****************************************************************
  // Falling-edge capture
  // ****************************************************************
  always_comb begin
    next_fl.word   = data_lanes;         // (R1)
    next_fl.marker = frame_marker_input; // (R5)
  end

  always_ff @(negedge source_sync_data_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      fl <= '0;
    end else begin
      fl <= next_fl;
    end
  end

  // ****************************************************************
  // Bit ordering
  // ****************************************************************
  for (genvar i = 0; i < LANES; i++) begin : g_rev
    assign rev_rise[i] = lk.rise_word[LANES-1-i]; // (R3)
    assign rev_fall[i] = fl.word[LANES-1-i];      // (R3)
  end

  // Lane index equals bit index unless the swap is set.
  assign ord_rise = lk.swap_q2 ? rev_rise : lk.rise_word; // (R2) (R3)
  assign ord_fall = lk.swap_q2 ? rev_fall : fl.word;      // (R2) (R3)

  // A frame begins where the rising-edge marker goes from low to high.
  // Edge alignment of marker and lanes lets both share one capture edge.
  assign link_sof = lk.frame_rise & ~lk.frame_prev; // (R7) (R6)

  // One entry per data clock: the rising word, then the falling word.
  always_comb begin
    wr_data                                  = '0;
    wr_data[LDDC_POS_RISE +: LANES]          = ord_rise; // (R1)
    wr_data[LDDC_POS_FALL +: LANES]          = ord_fall; // (R1)
    wr_data[LDDC_POS_SOF]                    = link_sof; // (R7)
    wr_data[LDDC_POS_PARITY]                 = fl.marker; // (R5)
  end

  // ****************************************************************
  // Rising-edge capture and push
  // ****************************************************************
  always_comb begin
    next_lk            = lk;
    next_lk.rise_word  = data_lanes;         // (R1)
    next_lk.frame_rise = frame_marker_input; // (R4)
    next_lk.primed     = 1'b1;
    next_lk.swap_q1    = bus_order_swap;
    next_lk.swap_q2    = lk.swap_q1;
    if (lk.primed) begin
      next_lk.frame_prev = lk.frame_rise;
      if (link_sof) begin
        next_lk.sof_tgl = ~lk.sof_tgl; // (R4)
      end
      // The source cannot be stalled; a full FIFO drops the entry and
      // the loss is reported rather than hidden.
      if (!wr_ready) begin
        next_lk.ovf_tgl = ~lk.ovf_tgl;
      end
    end
  end

  always_ff @(posedge source_sync_data_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ****************************************************************
  // Crossing FIFO
  // ****************************************************************
  logic          rd_valid;
  logic          rd_ready;
  logic [EW-1:0] rd_data;

  lddc_async_fifo #(
    .WIDTH (EW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .wr_clk   (source_sync_data_clock),
    .wr_rst_n (lrst_n),
    .wr_valid (lk.primed),
    .wr_ready (wr_ready),
    .wr_data  (wr_data),
    .rd_clk   (mclk),
    .rd_rst_n (mrst_n),
    .rd_valid (rd_valid),
    .rd_ready (rd_ready),
    .rd_data  (rd_data)
  );

  // ****************************************************************
  // System clock domain
  // ****************************************************************
  typedef struct packed {
    logic             sof_q1;
    logic             sof_q2;
    logic             sof_q3;
    logic             ovf_q1;
    logic             ovf_q2;
    logic             ovf_q3;
    logic             ovf_seen;
    logic             ptr_pulse;
    logic             sync_pulse;
    logic             v;
    logic [LANES-1:0] rise;
    logic [LANES-1:0] fall;
    logic             sof;
    logic             par;
  } lddc_sys_s;

  lddc_sys_s mk;
  lddc_sys_s next_mk;
  logic      sof_evt;
  logic      ovf_evt;

  assign rd_ready = ~mk.v | out_ready;
  assign sof_evt  = mk.sof_q2 ^ mk.sof_q3;
  assign ovf_evt  = mk.ovf_q2 ^ mk.ovf_q3;

  always_comb begin
    next_mk            = mk;
    next_mk.sof_q1     = lk.sof_tgl;
    next_mk.sof_q2     = mk.sof_q1;
    next_mk.sof_q3     = mk.sof_q2;
    next_mk.ovf_q1     = lk.ovf_tgl;
    next_mk.ovf_q2     = mk.ovf_q1;
    next_mk.ovf_q3     = mk.ovf_q2;
    next_mk.ptr_pulse  = sof_evt & ~frame_use_sync; // (R4)
    next_mk.sync_pulse = sof_evt & frame_use_sync;  // (R4)
    // A new loss in the clearing cycle keeps the flag set.
    if (overflow_clear) begin
      next_mk.ovf_seen = 1'b0;
    end
    if (ovf_evt) begin
      next_mk.ovf_seen = 1'b1;
    end
    if (rd_ready) begin
      next_mk.v    = rd_valid;
      next_mk.rise = rd_data[LDDC_POS_RISE +: LANES];
      next_mk.fall = rd_data[LDDC_POS_FALL +: LANES];
      next_mk.sof  = rd_data[LDDC_POS_SOF];    // (R7)
      next_mk.par  = rd_data[LDDC_POS_PARITY]; // (R5)
    end
  end

  always_ff @(posedge mclk or negedge mrst_n) begin
    if (!mrst_n) begin
      mk <= '0;
    end else begin
      mk <= next_mk;
    end
  end

  assign out_valid        = mk.v;
  assign out_rise_word    = mk.rise;
  assign out_fall_word    = mk.fall;
  assign out_sof          = mk.sof;
  assign out_parity       = mk.par;
  assign fifo_ptr_reset   = mk.ptr_pulse;
  assign frame_sync_pulse = mk.sync_pulse;
  assign overflow_seen    = mk.ovf_seen;
endmodule // lddc_capture
`default_nettype wire

// file: verification/lddc_chk.sv
// Checker on the output side of the sample capture block.
// Assumes it is bound into lddc_capture and sees only its ports.
`default_nettype none
module lddc_chk
  import lddc_pkg::*;
#(
  parameter int LANES = LDDC_LANES
) (
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             frame_use_sync,
  input wire logic             out_valid,
  input wire logic             out_ready,
  input wire logic [LANES-1:0] out_rise_word,
  input wire logic [LANES-1:0] out_fall_word,
  input wire logic             out_sof,
  input wire logic             out_parity,
  input wire logic             fifo_ptr_reset,
  input wire logic             frame_sync_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****
  // Entries hold while stalled
  // ****
  word_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_rise_word) && $stable(out_fall_word))
    else $error("words moved during stall");
  sof_hold_a: assert property (
    out_valid && !out_ready |=> $stable(out_sof)) else $error("frame start moved");
  parity_hold_a: assert property (
    out_valid && !out_ready |=> $stable(out_parity)) else $error("parity moved");
  // ****
  // Frame start pulses
  // ****
  ptr_single_a: assert property (
    fifo_ptr_reset |=> !fifo_ptr_reset) else $error("pointer pulse too long");
  sync_single_a: assert property (
    frame_sync_pulse |=> !frame_sync_pulse) else $error("sync pulse too long");
  ptr_mode_a: assert property (
    fifo_ptr_reset |-> !frame_use_sync) else $error("pointer pulse in sync mode");
  sync_mode_a: assert property (
    frame_sync_pulse |-> frame_use_sync) else $error("sync pulse in pointer mode");
  pulse_excl_a: assert property (
    !(fifo_ptr_reset && frame_sync_pulse)) else $error("both pulses at once");
endmodule // lddc_chk

bind lddc_capture lddc_chk #(.LANES(LANES)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .frame_use_sync(frame_use_sync), .out_valid(out_valid),
  .out_ready(out_ready), .out_rise_word(out_rise_word), .out_fall_word(out_fall_word),
  .out_sof(out_sof), .out_parity(out_parity), .fifo_ptr_reset(fifo_ptr_reset),
  .frame_sync_pulse(frame_sync_pulse)
);
`default_nettype wire

// file: verification/lddc_src_model.sv
// Behavioural sample source: lanes, frame marker and data clock.
// Assumes the bench calls send for one pair at a time; clock idles low between.
`default_nettype none
module lddc_src_model (
  output logic        src_clk,
  output logic [15:0] src_lanes,
  output logic        src_marker
);
  timeunit 1ns;
  timeprecision 10ps;
  initial begin
    src_clk = 1'b0;
    src_lanes = 16'h0000;
    src_marker = 1'b0;
  end
  // ****
  // One rising and one falling word
  // ****
  task automatic send(logic [15:0] r, f, logic mr, mf, int gap);
    src_lanes = r;
    src_marker = mr;
    #3.75 src_clk = 1'b1;
    #3.75 src_lanes = f;
    src_marker = mf;
    #3.75 src_clk = 1'b0;
    #3.75;
    // Hold is over, so no stale value is left for the sampler to find.
    // Back-to-back pairs skip this, since the next pair drives the lanes in this same step.
    if (gap > 0) begin
      src_lanes = ~f;
      src_marker = ~mf;
      #(gap);
    end
  endtask
endmodule // lddc_src_model
`default_nettype wire

// file: verification/lddc_tb.sv
// Self-checking bench for the sample capture block.
// Assumes the source model and the bound checker are compiled before it.
`default_nettype none
module testbench
  import lddc_pkg::*;
;
  timeunit 1ns;
  timeprecision 10ps;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        swap = 1'b0;
  logic        use_sync = 1'b0;
  logic        ovf_clr = 1'b0;
  logic        out_ready = 1'b0;
  logic        stall = 1'b1;
  logic        dclk, marker, ov, sof, par, ptr, syn, ovf;
  logic [15:0] lanes, rw, fw, p_r, p_f;
  logic        p_mr, p_mf, p_sof;
  logic [31:0] seed = 32'hd7dfd129;
  logic [LDDC_ENTRY_W-1:0] exp_q[$];
  int          errors, checks, n_ptr, n_sync, e_ptr, e_sync, n_free;
  bit          armed;

  lddc_src_model src (.src_clk(dclk), .src_lanes(lanes), .src_marker(marker));
  lddc_capture DUT (.mclk(mclk), .rst_n(rst_n), .source_sync_data_clock(dclk),
    .data_lanes(lanes), .frame_marker_input(marker), .bus_order_swap(swap),
    .frame_use_sync(use_sync), .overflow_clear(ovf_clr), .out_valid(ov),
    .out_ready(out_ready), .out_rise_word(rw), .out_fall_word(fw), .out_sof(sof),
    .out_parity(par), .fifo_ptr_reset(ptr), .frame_sync_pulse(syn), .overflow_seen(ovf));

  initial forever #10 mclk = ~mclk;

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] fix(logic [15:0] w);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = w[15-i];
    return swap ? r : w;
  endfunction
  task automatic compare(logic [LDDC_ENTRY_W-1:0] got, exp, string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_cyc(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // A pair is pushed at the next rising edge, so expectations lag one pair.
  task automatic pair(logic [15:0] r, f, logic mr, mf, int gap);
    if (armed) exp_q.push_back({fix(p_r), fix(p_f), p_sof, p_mf});
    if (p_sof && use_sync) e_sync++;
    if (p_sof && !use_sync) e_ptr++;
    p_sof = mr && !p_mr;
    {p_r, p_f, p_mr, p_mf} = {r, f, mr, mf};
    src.send(r, f, mr, mf, gap);
  endtask
  // Zero guards make the swap setting invisible while it crosses into the link domain.
  task automatic burst(int n, int gap);
    logic [31:0] v;
    repeat (3) pair(16'h0000, 16'h0000, 1'b0, 1'b0, gap);
    for (int i = 0; i < n; i++) begin
      v = (i == 0) ? 32'h8000_0001 : rnd();
      pair(v[31:16], v[15:0], gap > 0 && i % 6 < 2, v[7], gap);
    end
    pair(16'h0000, 16'h0000, 1'b0, 1'b0, gap);
  endtask
  task automatic drain();
    for (int k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge mclk);
    if (exp_q.size() > 0) begin
      errors++;
      $display("Error at %0t: entries missing", $time);
      end_sim();
    end
    wait_cyc(8);
  endtask

  // ****
  // Output monitor and consumer
  // ****
  always @(posedge mclk) begin
    if (ptr === 1'b1) n_ptr++;
    if (syn === 1'b1) n_sync++;
    if (ov === 1'b1 && out_ready === 1'b1 && !armed) n_free++;
    if (ov === 1'b1 && out_ready === 1'b1 && armed) begin
      if (exp_q.size() == 0) compare(1, 0, "extra entry");
      else compare({rw, fw, sof, par}, exp_q.pop_front(), "entry");
    end
    out_ready <= #1 !stall && rnd() % 4 != 0;
  end

  // ****
  // Main sequence
  // ****
  initial begin
    fork
      wait_cyc(10);
      repeat (6) pair(16'h0000, 16'h0000, 1'b0, 1'b0, 5);
    join
    rst_n = 1'b1;
    stall = 1'b0;
    repeat (6) pair(16'h0000, 16'h0000, 1'b0, 1'b0, 25);
    wait_cyc(30);
    armed = 1'b1;
    for (int m = 0; m < 4; m++) begin
      {swap, use_sync} = 2'(m);
      burst(24, 25);
      drain();
    end
    compare(34'(n_ptr), 34'(e_ptr), "pointer pulses");
    compare(34'(n_sync), 34'(e_sync), "sync pulses");
    compare(ovf, 0, "overflow early");
    stall = 1'b1;
    armed = 1'b0;
    n_free = 0;
    burst(14, 0);
    wait_cyc(10);
    compare(ovf, 1, "overflow flag");
    stall = 1'b0;
    wait_cyc(60);
    compare(n_free >= LDDC_FIFO_DEPTH && n_free <= LDDC_FIFO_DEPTH + 1, 1, "kept");
    // The write side learns of the drain only at link edges. Its stale full view
    // drops the first two pushes after a stall, so unchecked zero pairs absorb them.
    repeat (3) pair(16'h0000, 16'h0000, 1'b0, 1'b0, 25);
    wait_cyc(20);
    ovf_clr = 1'b1;
    wait_cyc(1);
    ovf_clr = 1'b0;
    wait_cyc(4);
    compare(ovf, 0, "overflow cleared");
    armed = 1'b1;
    swap = 1'b1;
    burst(12, 25);
    drain();
    end_sim();
  end

  initial begin
    #2ms;
    errors++;
    $display("Error at %0t: timeout", $time);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
